// ---- hw/jtpi_pkg.sv ----
// =====================================================================
// Shared constants and types of the test access port
// =====================================================================
package jtpi_pkg;

  localparam int IR_W       = 4;
  localparam int DR_W       = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_W     = 3;

  // Instruction codes
  localparam logic [IR_W-1:0] INSN_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] INSN_INTEST = 4'h1;
  localparam logic [IR_W-1:0] INSN_USER   = 4'h8;
  localparam logic [IR_W-1:0] INSN_IDCODE = 4'he;
  localparam logic [IR_W-1:0] INSN_BYPASS = 4'hf;

  // Value loaded into the instruction chain in Capture-IR
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 4'h1;

  // Identification word; value is arbitrary, bit 0 must stay set
  localparam logic [DR_W-1:0] IDCODE_DEFAULT = 32'h0ace_0001;

  // Value of the alternate-function select bit after reset
  localparam logic ALT_FN_RESET = 1'b1;

  // Sampled pin vector positions
  localparam int PIN_TCK = 0;
  localparam int PIN_TMS = 1;
  localparam int PIN_TDI = 2;

  typedef enum logic [3:0] {
    TAP_RESET,
    TAP_IDLE,
    TAP_SEL_DR,
    TAP_CAP_DR,
    TAP_SHIFT_DR,
    TAP_EXIT1_DR,
    TAP_PAUSE_DR,
    TAP_EXIT2_DR,
    TAP_UPD_DR,
    TAP_SEL_IR,
    TAP_CAP_IR,
    TAP_SHIFT_IR,
    TAP_EXIT1_IR,
    TAP_PAUSE_IR,
    TAP_EXIT2_IR,
    TAP_UPD_IR
  } jtpi_state_t;

  typedef enum logic [1:0] {
    SEL_BYPASS,
    SEL_IDCODE,
    SEL_USER,
    SEL_HOLD
  } jtpi_sel_t;

endpackage

// ---- hw/jtpi_stream_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// =====================================================================
// Word stream between buffer and scan logic
// =====================================================================
interface jtpi_stream_if #(
  parameter int W = 32
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- hw/jtpi_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none
// =====================================================================
// Word buffer in front of the user data chain
// =====================================================================
module jtpi_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output var  logic             in_ready_o,
  // Drain side
  jtpi_stream_if.src            out
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("jtpi_fifo: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push      = in_valid_i && in_ready_o;
  assign pop       = out.valid && out.ready;
  assign out.valid = (count != '0);
  assign out.data  = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // Ready is a flop: full is known one cycle ahead from next_count
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count      <= '0;
      in_ready_o <= 1'b1;
    end else begin
      count      <= next_count;
      in_ready_o <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule
`default_nettype wire

// ---- hw/jtpi_tap.sv ----
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - State moves only on test clock rising edges
// - TAP state drives capture, shift and update
// - State picks instruction chain or data chain
// - Current instruction picks which data chain
// - EXTEST and INTEST never capture, shift, update
// - Unimplemented codes decode as BYPASS
// - Test reset low forces and holds reset state
// - Entering reset state loads IDCODE instruction
// - Test logic advances only on test clock
// - Stopped test clock preserves state and registers
// - Mode select sampled at rising edge
// - Five mode-select-high clocks reach reset state
// - Data input sampled at rising edge, routed
// - Pins default to alternate function after reset
// - Pin reassignment needs commit unlock in the same cycle as the write
// - Instruction chain is four bits wide
// - Data output changes on falling edge, idle undriven
// - Update transfers chain, capture samples new data
module jtpi_tap
  import jtpi_pkg::*;
#(
  parameter logic [DR_W-1:0] IDCODE_VALUE = IDCODE_DEFAULT
) (
  // System clock and reset
  input  wire logic            clk_i,
  input  wire logic            arst_n_i,
  // Test port pins
  input  wire logic            trst_n_i,
  input  wire logic            tck_i,
  input  wire logic            tms_i,
  input  wire logic            tdi_i,
  output var  logic            tdo_o,
  output var  logic            tdo_oe_o,
  // Pin function control
  input  wire logic            alt_fn_wr_i,
  input  wire logic            alt_fn_data_i,
  input  wire logic            commit_unlock_i,
  output var  logic            alt_function_select_bit_o,
  // Words offered to the user data chain capture
  input  wire logic            cap_valid_i,
  input  wire logic [DR_W-1:0] cap_data_i,
  output var  logic            cap_ready_o,
  // Words delivered by user data chain update
  output var  logic [DR_W-1:0] upd_data_o,
  output var  logic            upd_valid_o,
  // Observed state
  output var  logic [IR_W-1:0] insn_o,
  output var  logic            tap_reset_o
);

  generate
    if (IDCODE_VALUE[0] != 1'b1) begin : g_bad_id
      $error("jtpi_tap: IDCODE_VALUE bit 0 must be one");
    end
  endgenerate

  // ===================================================================
  // Reset and pin sampling
  // ===================================================================
  logic              rst_n;
  logic [SYNC_W-1:0] pin_s1;
  logic [SYNC_W-1:0] pin_s2;
  logic              tck_s3;
  logic              tck_rise;
  logic              tck_fall;
  logic              tms;
  logic              tdi;

  assign rst_n = arst_n_i & trst_n_i;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      tck_s3 <= 1'b0;
    end else begin
      pin_s1 <= {tdi_i, tms_i, tck_i};
      pin_s2 <= pin_s1;
      tck_s3 <= pin_s2[PIN_TCK];
    end
  end

  // Only edges of the test clock move the test logic
  assign tck_rise = pin_s2[PIN_TCK] & ~tck_s3;
  assign tck_fall = ~pin_s2[PIN_TCK] & tck_s3;
  assign tms      = pin_s2[PIN_TMS];
  assign tdi      = pin_s2[PIN_TDI];

  // ===================================================================
  // Instruction decode
  // ===================================================================
  function automatic jtpi_sel_t dr_select(input logic [IR_W-1:0] insn);
    jtpi_sel_t sel;
    sel = SEL_BYPASS;
    case (insn)
      INSN_IDCODE: sel = SEL_IDCODE;
      INSN_USER:   sel = SEL_USER;
      INSN_EXTEST,
      INSN_INTEST: sel = SEL_HOLD;
      default:     sel = SEL_BYPASS;
    endcase
    return sel;
  endfunction

  // ===================================================================
  // TAP controller
  // ===================================================================
  jtpi_state_t     state;
  jtpi_state_t     next_state;
  logic [IR_W-1:0] ir_chain;
  logic [IR_W-1:0] ir_cur;
  jtpi_sel_t       sel;

  assign sel = dr_select(ir_cur);

  always_comb begin
    next_state = state;
    case (state)
      TAP_RESET:    next_state = tms ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     next_state = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   next_state = tms ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   next_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: next_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: next_state = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: next_state = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: next_state = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   next_state = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   next_state = tms ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   next_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: next_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: next_state = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: next_state = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: next_state = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   next_state = tms ? TAP_SEL_DR   : TAP_IDLE;
      default:      next_state = TAP_RESET;
    endcase
  end

  // Five rising edges with mode select high reach reset from anywhere
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= TAP_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // ===================================================================
  // Instruction chain
  // ===================================================================
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ir_chain <= IR_CAPTURE_VAL;
      ir_cur   <= INSN_IDCODE;
    end else if (tck_rise) begin
      case (state)
        TAP_RESET:    ir_cur   <= INSN_IDCODE;
        TAP_CAP_IR:   ir_chain <= IR_CAPTURE_VAL;
        TAP_SHIFT_IR: ir_chain <= {tdi, ir_chain[IR_W-1:1]};
        TAP_UPD_IR:   ir_cur   <= ir_chain;
        default:      ir_chain <= ir_chain;
      endcase
      // Entry by mode select also restores the default instruction
      if (next_state == TAP_RESET) begin
        ir_cur <= INSN_IDCODE;
      end
    end
  end

  // ===================================================================
  // Data chains
  // ===================================================================
  logic            byp_chain;
  logic [DR_W-1:0] dr_chain;
  logic            cap_pop;

  jtpi_stream_if #(.W(DR_W)) cap_if ();

  jtpi_fifo #(
    .WIDTH (DR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_cap_fifo (
    .clk_i      (clk_i),
    .arst_n_i   (rst_n),
    .in_valid_i (cap_valid_i),
    .in_data_i  (cap_data_i),
    .in_ready_o (cap_ready_o),
    .out        (cap_if)
  );

  // One word leaves the buffer per user capture, if one is waiting
  assign cap_pop      = tck_rise && (state == TAP_CAP_DR) && (sel == SEL_USER);
  assign cap_if.ready = cap_pop;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      byp_chain <= 1'b0;
    end else if (tck_rise && sel == SEL_BYPASS) begin
      case (state)
        TAP_CAP_DR:   byp_chain <= 1'b0;
        TAP_SHIFT_DR: byp_chain <= tdi;
        default:      byp_chain <= byp_chain;
      endcase
    end
  end

  // Identification and user words share one chain; hold mode leaves it
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dr_chain <= '0;
    end else if (tck_rise && (sel == SEL_IDCODE || sel == SEL_USER)) begin
      case (state)
        TAP_CAP_DR: begin
          if (sel == SEL_IDCODE) begin
            dr_chain <= IDCODE_VALUE;
          end else begin
            dr_chain <= cap_if.valid ? cap_if.data : '0;
          end
        end
        TAP_SHIFT_DR: dr_chain <= {tdi, dr_chain[DR_W-1:1]};
        default:      dr_chain <= dr_chain;
      endcase
    end
  end

  // Update of the user chain hands its word to the system side
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      upd_data_o  <= '0;
      upd_valid_o <= 1'b0;
    end else begin
      upd_valid_o <= 1'b0;
      if (tck_rise && state == TAP_UPD_DR && sel == SEL_USER) begin
        upd_data_o  <= dr_chain;
        upd_valid_o <= 1'b1;
      end
    end
  end

  // ===================================================================
  // Serial data output
  // ===================================================================
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_o <= 1'b0;
      if (state == TAP_SHIFT_IR) begin
        tdo_o    <= ir_chain[0];
        tdo_oe_o <= 1'b1;
      end else if (state == TAP_SHIFT_DR && sel != SEL_HOLD) begin
        tdo_o    <= (sel == SEL_BYPASS) ? byp_chain : dr_chain[0];
        tdo_oe_o <= 1'b1;
      end
    end
  end

  // ===================================================================
  // Pin function select and observed state
  // ===================================================================
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alt_function_select_bit_o <= ALT_FN_RESET;
    end else if (alt_fn_wr_i && commit_unlock_i) begin
      alt_function_select_bit_o <= alt_fn_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      insn_o      <= INSN_IDCODE;
      tap_reset_o <= 1'b1;
    end else begin
      insn_o      <= ir_cur;
      tap_reset_o <= (state == TAP_RESET);
    end
  end

endmodule
`default_nettype wire

// ---- tb/jtpi_tap_props.sv ----
`timescale 1ns/100ps
`default_nettype none
// =====================================================================
// Port-level checks of the test access port
// =====================================================================
module jtpi_tap_props
  import jtpi_pkg::*;
(
  // Clocks and resets
  input wire logic            clk_i,
  input wire logic            arst_n_i,
  input wire logic            trst_n_i,
  // Link and pin function
  input wire logic            tck_i,
  input wire logic            tdo_o,
  input wire logic            tdo_oe_o,
  input wire logic            alt_fn_wr_i,
  input wire logic            alt_fn_data_i,
  input wire logic            commit_unlock_i,
  input wire logic            alt_function_select_bit_o,
  // Buffer, update and state
  input wire logic            cap_valid_i,
  input wire logic            cap_ready_o,
  input wire logic            upd_valid_o,
  input wire logic [IR_W-1:0] insn_o,
  input wire logic            tap_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  trst_hold_a: assert property (!trst_n_i |-> tap_reset_o &&
    insn_o == INSN_IDCODE && !tdo_oe_o)
    else $error("test reset does not hold the reset state");
  alt_keep_a: assert property (!(alt_fn_wr_i && commit_unlock_i) |=>
    $stable(alt_function_select_bit_o))
    else $error("pin function changed without unlock");
  alt_write_a: assert property (alt_fn_wr_i && commit_unlock_i |=>
    alt_function_select_bit_o == $past(alt_fn_data_i))
    else $error("unlocked pin function write lost");
  tck_static_a: assert property ((trst_n_i && $stable(tck_i)) [*8] |->
    $stable(insn_o) && $stable(tap_reset_o))
    else $error("state moved while test clock stood");
  upd_user_a: assert property (upd_valid_o |->
    insn_o == INSN_USER ##1 !upd_valid_o)
    else $error("update pulse wrong");
  tdo_fall_a: assert property ($changed(tdo_o) && trst_n_i &&
    $past(trst_n_i) |-> !tck_i && !$past(tck_i))
    else $error("data output changed outside falling edge");
  oe_idle_a: assert property (tdo_oe_o |-> !tap_reset_o)
    else $error("data output driven in reset state");
  ready_fall_a: assert property ($fell(cap_ready_o) |-> $past(cap_valid_i))
    else $error("buffer ready fell without push");
endmodule

bind jtpi_tap jtpi_tap_props props_u (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .trst_n_i(trst_n_i), .tck_i(tck_i),
  .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .alt_fn_wr_i(alt_fn_wr_i),
  .alt_fn_data_i(alt_fn_data_i), .commit_unlock_i(commit_unlock_i),
  .alt_function_select_bit_o(alt_function_select_bit_o),
  .cap_valid_i(cap_valid_i), .cap_ready_o(cap_ready_o),
  .upd_valid_o(upd_valid_o), .insn_o(insn_o), .tap_reset_o(tap_reset_o)
);
`default_nettype wire

// ---- tb/jtpi_host.sv ----
`timescale 1ns/100ps
`default_nettype none
// =====================================================================
// Test host driving the link; clock stands low between frames
// =====================================================================
module jtpi_host (
  // Test port pins
  output var  logic tck_o,
  output var  logic tms_o,
  output var  logic tdi_o,
  input  wire logic tdo_i
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // One test clock period, inputs change right after the fall
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o <= tms;
    tdi_o <= tdi;
    #400 tck_o <= 1'b1;
    tdo = tdo_i;
    #400 tck_o <= 1'b0;
  endtask

  // Idle to idle scan of n bits, LSB first
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic b;
    dout = '0;
    step(1'b1, 1'b0, b);
    if (ir) begin
      step(1'b1, 1'b0, b);
    end
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_jtag_tap_pin_interface.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_jtag_tap_pin_interface
  import jtpi_pkg::*;
;
  logic clk_i, arst_n_i, trst_n_i, tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o;
  logic alt_fn_wr_i, alt_fn_data_i, commit_unlock_i, alt_bit;
  logic cap_valid_i, cap_ready_o, upd_valid_o, tap_reset_o, b;
  logic [31:0] cap_data_i, upd_data_o, d, r, w[8], exp_q[$];
  logic [3:0]  insn_o;
  int          bad_count, samples_checked;
  // Pull-up holds the data output high while undriven
  wire logic   tdo_w = tdo_oe_o ? tdo_o : 1'b1;
  logic [3:0]  byp[2] = '{4'h2, INSN_BYPASS};
  logic [3:0]  hold[2] = '{INSN_EXTEST, INSN_INTEST};

  jtpi_tap dut_u (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .trst_n_i(trst_n_i), .tck_i(tck_i),
    .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
    .alt_fn_wr_i(alt_fn_wr_i), .alt_fn_data_i(alt_fn_data_i),
    .commit_unlock_i(commit_unlock_i), .alt_function_select_bit_o(alt_bit),
    .cap_valid_i(cap_valid_i), .cap_data_i(cap_data_i),
    .cap_ready_o(cap_ready_o), .upd_data_o(upd_data_o),
    .upd_valid_o(upd_valid_o), .insn_o(insn_o), .tap_reset_o(tap_reset_o));
  jtpi_host host_u (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i),
    .tdo_i(tdo_w));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_ir(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: code %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic ir_load(input logic [3:0] code);
    host_u.scan(1'b1, 4, {28'h0, code}, d);
    chk_ir(d[3:0], IR_CAPTURE_VAL);
    repeat (2) @(posedge clk_i);
    chk_ir(insn_o, code);
  endtask
  task automatic alt_write(input logic v, input logic unl, input logic e);
    @(posedge clk_i);
    alt_fn_wr_i     <= 1'b1;
    alt_fn_data_i   <= v;
    commit_unlock_i <= unl;
    @(posedge clk_i);
    alt_fn_wr_i <= 1'b0;
    @(posedge clk_i);
    @(posedge clk_i);
    chk_bit(alt_bit, e);
  endtask

  // Update words are matched against the oldest note
  always @(posedge clk_i) begin
    if (upd_valid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk_bit(1'b1, 1'b0);
      end else begin
        chk_word(upd_data_o, exp_q.pop_front());
      end
    end
  end

  initial begin
    #2000000;
    bad_count++;
    wrap_up();
  end

  initial begin
    {arst_n_i, alt_fn_wr_i, alt_fn_data_i, commit_unlock_i} = '0;
    {trst_n_i, cap_valid_i, cap_data_i} = {1'b1, 33'h0};
    void'($urandom(32'h7115));
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    chk_bit(tap_reset_o, 1'b1);
    chk_ir(insn_o, INSN_IDCODE);
    chk_bit(tdo_oe_o, 1'b0);
    chk_bit(alt_bit, ALT_FN_RESET);
    chk_bit(cap_ready_o, 1'b1);
    host_u.step(1'b0, 1'b0, b);
    host_u.scan(1'b0, 32, $urandom, d);
    chk_word(d, IDCODE_DEFAULT);
    $display("reset and identification test done");
    foreach (byp[k]) begin
      ir_load(byp[k]);
      r = $urandom;
      host_u.scan(1'b0, 8, r, d);
      chk_word(d, {24'h0, r[6:0], 1'b0});
    end
    $display("bypass test done");
    for (int i = 0; i < 9; i++) begin
      w[i % 8] = (i < 8) ? $urandom : w[i % 8];
      @(posedge clk_i);
      cap_valid_i <= 1'b1;
      cap_data_i  <= (i < 8) ? w[i] : $urandom;
    end
    repeat (3) @(posedge clk_i);
    cap_valid_i <= 1'b0;
    chk_bit(cap_ready_o, 1'b0);
    ir_load(INSN_USER);
    for (int i = 0; i < 9; i++) begin
      r = $urandom;
      exp_q.push_back(r);
      host_u.scan(1'b0, 32, r, d);
      chk_word(d, (i < 8) ? w[i] : 32'h0);
    end
    chk_bit(cap_ready_o, 1'b1);
    $display("user chain and buffer test done");
    foreach (hold[k]) begin
      ir_load(hold[k]);
      host_u.scan(1'b0, 32, $urandom, d);
      chk_word(d, 32'hffff_ffff);
    end
    $display("hold instruction test done");
    ir_load(INSN_USER);
    exp_q.push_back(32'h0);
    host_u.step(1'b1, 1'b0, b);
    host_u.step(1'b0, 1'b0, b);
    host_u.step(1'b0, 1'b0, b);
    repeat (5) host_u.step(1'b1, 1'b0, b);
    repeat (2) @(posedge clk_i);
    chk_bit(tap_reset_o, 1'b1);
    chk_ir(insn_o, INSN_IDCODE);
    host_u.step(1'b0, 1'b0, b);
    ir_load(4'h3);
    repeat (50) @(posedge clk_i);
    chk_ir(insn_o, 4'h3);
    trst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk_bit(tap_reset_o, 1'b1);
    chk_ir(insn_o, INSN_IDCODE);
    trst_n_i <= 1'b1;
    host_u.step(1'b0, 1'b0, b);
    $display("mode select and test reset test done");
    alt_write(1'b0, 1'b0, 1'b1);
    alt_write(1'b0, 1'b1, 1'b0);
    alt_write(1'b1, 1'b1, 1'b1);
    $display("pin function test done");
    chk_word(32'(exp_q.size()), 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
